// file: include/pbt_pkg.sv
// ----------------------------------------------------------------
// shared constants and types for the per-stream error rate test
// ----------------------------------------------------------------
package pbt_pkg;

  localparam int          NUM_STREAMS  = 32;
  localparam int          SEQ_WIDTH    = 15;
  localparam int          CNT_WIDTH    = 16;

  // register bus geometry: global register at 80 only; other addr[7] addresses unmapped
  localparam logic [7:0]  ADDR_GLOBAL  = 8'h80;
  localparam logic [1:0]  REG_CONTROL  = 2'h0;
  localparam logic [1:0]  REG_START    = 2'h1;
  localparam logic [1:0]  REG_LENGTH   = 2'h2;
  localparam logic [1:0]  REG_ERRORS   = 2'h3;

  // field positions
  localparam int          CTL_ENABLE_BIT = 0;
  localparam int          CTL_CLEAR_BIT  = 1;
  localparam int          GLB_TX_BIT     = 4;
  localparam int          GLB_RX_BIT     = 5;
  localparam int          CM_MODE_BIT    = 0;

  // connection word per-channel control code selecting pattern output
  localparam logic [1:0]  PCC_PATTERN  = 2'h2;

  // reset values, count limit and sequence seed
  localparam logic [7:0]  START_RESET  = 8'h00;
  localparam logic [8:0]  LENGTH_RESET = 9'h001;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [14:0] SEQ_SEED     = 15'h7FFF;

  // per-stream checker settings
  typedef struct packed {
    logic       enable;
    logic [7:0] start;
    logic [8:0] length;
  } pbt_cfg_t;

  // bit and channel timing from the switch core
  typedef struct packed {
    logic       frame_start;
    logic       bit_strobe;
    logic       first_bit;
    logic [7:0] chan;
  } pbt_timing_t;

  // one step of x^15 + x^14 + 1
  function automatic logic [14:0] pbt_seq_next(input logic [14:0] s);
    pbt_seq_next = {s[13:0], s[14] ^ s[13]};
  endfunction

endpackage

// file: design/pbt_stream.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// one stream: pattern transmitter, checker and error counter
// ----------------------------------------------------------------
module pbt_stream (
  input  wire logic                mclk,      // 10 MHz clock
  input  wire logic                reset_n,   // async reset
  input  wire pbt_pkg::pbt_timing_t tim,      // bit timing
  input  wire logic                rx_glob,   // global checker enable
  input  wire logic                tx_glob,   // global transmit enable
  input  wire pbt_pkg::pbt_cfg_t   cfg,       // checker settings
  input  wire logic                clear,     // count clear pulse
  input  wire logic                rx_bit,    // received bit
  input  wire logic [2:0]          cm_low,    // connection word low
  output logic                     tx_bit,    // pattern bit
  output logic                     tx_on,     // channel carries pattern
  output logic [15:0]              err_count  // saturating count
);

  logic [14:0] rx_seq_q, rx_seq_d, rx_cur;
  logic [14:0] tx_seq_q, tx_seq_d, tx_cur;
  logic        tx_prev_q, tx_prev_d;
  logic [15:0] err_q, err_d;
  logic [9:0]  win_end;
  logic        in_win, rx_act, mismatch, tx_act;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    win_end  = {2'b00, cfg.start} + {1'b0, cfg.length};
    in_win   = (tim.chan >= cfg.start) && ({2'b00, tim.chan} < win_end);
    rx_act   = rx_glob && cfg.enable && tim.bit_strobe && in_win;
    // restart at window's first bit
    rx_cur   = (tim.chan == cfg.start && tim.first_bit) ?
               pbt_pkg::SEQ_SEED : rx_seq_q;
    mismatch = rx_act && (rx_bit != rx_cur[14]);
    rx_seq_d = rx_act ? pbt_pkg::pbt_seq_next(rx_cur) : rx_seq_q;
    err_d    = err_q;
    if (clear) begin
      err_d = mismatch ? 16'h0001 : 16'h0000;
    end else if (mismatch && err_q != pbt_pkg::CNT_MAX) begin
      err_d = err_q + 16'h0001;
    end
    // pattern only with mode bit set and control code 10
    tx_on    = tx_glob && cm_low[pbt_pkg::CM_MODE_BIT] &&
               (cm_low[2:1] == pbt_pkg::PCC_PATTERN);
    tx_act   = tx_on && tim.bit_strobe;
    tx_cur   = tx_prev_q ? tx_seq_q : pbt_pkg::SEQ_SEED;
    tx_bit   = tx_cur[14];
    tx_seq_d = tx_act ? pbt_pkg::pbt_seq_next(tx_cur) : tx_seq_q;
    tx_prev_d = tim.frame_start ? 1'b0 :
                (tim.bit_strobe ? tx_on : tx_prev_q);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_seq_q  <= pbt_pkg::SEQ_SEED;
      tx_seq_q  <= pbt_pkg::SEQ_SEED;
      tx_prev_q <= 1'b0;
      err_q     <= 16'h0000;
    end else begin
      rx_seq_q  <= rx_seq_d;
      tx_seq_q  <= tx_seq_d;
      tx_prev_q <= tx_prev_d;
      err_q     <= err_d;
    end
  end

  assign err_count = err_q;

endmodule

// file: design/pbt_top.sv
`timescale 1ns/100ps
// Function
// - one transmitter per output stream, one checker per input stream, 32
// - transmitters send the 2^15-1 pseudo-random sequence
// - pattern may start at any channel, last one channel to a frame
// - global rx enable bit 5, tx enable bit 4; both off at reset
// - control bit 1 write clears count; bit 0 enables checker
// - start field bits 7..0 picks first checked channel
// - length field bits 8..0 sets checked channels, one or more
// - error count is read-only and saturates at FFFF
// - output carries pattern only with mode bit 1, control 10
// - each checker has a 16-bit error counter
module pbt_top #(
  parameter int STREAMS = pbt_pkg::NUM_STREAMS
) (
  input  wire logic                mclk,        // 10 MHz clock
  input  wire logic                reset_n,     // async reset
  input  wire logic                reg_wr,      // write strobe
  input  wire logic                reg_rd,      // read strobe
  input  wire logic [7:0]          reg_addr,    // register address
  input  wire logic [15:0]         reg_wdata,   // write data
  output logic      [15:0]         reg_rdata,   // read data, registered
  input  wire pbt_pkg::pbt_timing_t tim,        // bit and channel timing
  input  wire logic [STREAMS-1:0]  rx_bits,     // received bit per stream
  input  wire logic [STREAMS-1:0][2:0] cm_low,  // connection word low
  output logic      [STREAMS-1:0]  tx_bits,     // pattern bits
  output logic      [STREAMS-1:0]  tx_on        // pattern active
);

  logic              rx_glob_q, rx_glob_d;
  logic              tx_glob_q, tx_glob_d;
  pbt_pkg::pbt_cfg_t cfg_q [STREAMS];
  pbt_pkg::pbt_cfg_t cfg_d [STREAMS];
  logic [STREAMS-1:0] clear_vec;
  logic [15:0]       err_cnt [STREAMS];
  logic [STREAMS-1:0] tx_bit_w, tx_on_w;
  logic [15:0]       rdata_q, rdata_d;
  logic [STREAMS-1:0] tx_bits_q, tx_bits_d, tx_on_q, tx_on_d;
  logic [4:0]        sel;
  logic [1:0]        reg_id;
  logic              is_stream;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    sel       = reg_addr[6:2];
    reg_id    = reg_addr[1:0];
    is_stream = !reg_addr[7] && (int'(sel) < STREAMS);
    rx_glob_d = rx_glob_q;
    tx_glob_d = tx_glob_q;
    clear_vec = '0;
    for (int i = 0; i < STREAMS; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (reg_wr && reg_addr == pbt_pkg::ADDR_GLOBAL) begin
      rx_glob_d = reg_wdata[pbt_pkg::GLB_RX_BIT];
      tx_glob_d = reg_wdata[pbt_pkg::GLB_TX_BIT];
    end else if (reg_wr && is_stream && reg_id == pbt_pkg::REG_CONTROL) begin
      cfg_d[sel].enable = reg_wdata[pbt_pkg::CTL_ENABLE_BIT];
      clear_vec[sel]    = reg_wdata[pbt_pkg::CTL_CLEAR_BIT];
    end else if (reg_wr && is_stream && reg_id == pbt_pkg::REG_START) begin
      cfg_d[sel].start = reg_wdata[7:0];
    end else if (reg_wr && is_stream && reg_id == pbt_pkg::REG_LENGTH) begin
      // zero would disable the window; hold the minimum of one
      cfg_d[sel].length = (reg_wdata[8:0] == 9'h000) ?
                          9'h001 : reg_wdata[8:0];
    end
  end

  // ----------------------------------------------------------------
  // register reads, unmapped addresses return zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = 16'h0000;
      if (reg_addr == pbt_pkg::ADDR_GLOBAL) begin
        rdata_d[pbt_pkg::GLB_RX_BIT] = rx_glob_q;
        rdata_d[pbt_pkg::GLB_TX_BIT] = tx_glob_q;
      end else if (is_stream && reg_id == pbt_pkg::REG_CONTROL) begin
        rdata_d[pbt_pkg::CTL_ENABLE_BIT] = cfg_q[sel].enable;
      end else if (is_stream && reg_id == pbt_pkg::REG_START) begin
        rdata_d[7:0] = cfg_q[sel].start;
      end else if (is_stream && reg_id == pbt_pkg::REG_LENGTH) begin
        rdata_d[8:0] = cfg_q[sel].length;
      end else if (is_stream && reg_id == pbt_pkg::REG_ERRORS) begin
        rdata_d = err_cnt[sel];
      end
    end
    tx_bits_d = tx_bit_w & tx_on_w;
    tx_on_d   = tx_on_w;
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_glob_q <= 1'b0;
      tx_glob_q <= 1'b0;
      for (int i = 0; i < STREAMS; i++) begin
        cfg_q[i] <= '{enable: 1'b0, start: pbt_pkg::START_RESET,
                      length: pbt_pkg::LENGTH_RESET};
      end
      rdata_q   <= 16'h0000;
      tx_bits_q <= '0;
      tx_on_q   <= '0;
    end else begin
      rx_glob_q <= rx_glob_d;
      tx_glob_q <= tx_glob_d;
      for (int i = 0; i < STREAMS; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      rdata_q   <= rdata_d;
      tx_bits_q <= tx_bits_d;
      tx_on_q   <= tx_on_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign tx_bits   = tx_bits_q;
  assign tx_on     = tx_on_q;

  // ----------------------------------------------------------------
  // per-stream test channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < STREAMS; g++) begin : g_stream
    pbt_stream u_stream (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .tim       (tim),
      .rx_glob   (rx_glob_q),
      .tx_glob   (tx_glob_q),
      .cfg       (cfg_q[g]),
      .clear     (clear_vec[g]),
      .rx_bit    (rx_bits[g]),
      .cm_low    (cm_low[g]),
      .tx_bit    (tx_bit_w[g]),
      .tx_on     (tx_on_w[g]),
      .err_count (err_cnt[g])
    );
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic glob_wr;
  logic ctl0_wr;
  assign glob_wr = reg_wr && reg_addr == pbt_pkg::ADDR_GLOBAL;
  assign ctl0_wr = reg_wr && reg_addr == 8'h00;

  property p_glob_hold;
    @(posedge mclk) disable iff (!reset_n)
      !glob_wr |=> $stable(rx_glob_q) && $stable(tx_glob_q);
  endproperty
  a_glob_hold: assert property (p_glob_hold)
    else $error("global enable changed without a write");

  property p_tx_off;
    @(posedge mclk) disable iff (!reset_n)
      !tx_glob_q ##1 !tx_glob_q |-> tx_on == '0;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("pattern output while transmit test disabled");

  property p_tx_select;
    @(posedge mclk) disable iff (!reset_n)
      tx_glob_q && cm_low[0] == 3'b101 |=> tx_on[0];
  endproperty
  a_tx_select: assert property (p_tx_select)
    else $error("stream 0 pattern not selected by code 10");

  property p_tx_wrong_code;
    @(posedge mclk) disable iff (!reset_n)
      cm_low[0][2:1] != 2'b10 || !cm_low[0][0] |=> !tx_on[0] && !tx_bits[0];
  endproperty
  a_tx_wrong_code: assert property (p_tx_wrong_code)
    else $error("stream 0 pattern on a channel not set for it");

  property p_saturate;
    @(posedge mclk) disable iff (!reset_n)
      err_cnt[0] == 16'hFFFF && !clear_vec[0] |=> err_cnt[0] == 16'hFFFF;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("error count wrapped");

  property p_clear;
    @(posedge mclk) disable iff (!reset_n)
      ctl0_wr && reg_wdata[1] |=> err_cnt[0] <= 16'h0001;
  endproperty
  a_clear: assert property (p_clear)
    else $error("error count not cleared");

  property p_step_one;
    @(posedge mclk) disable iff (!reset_n)
      !clear_vec[0] |=> err_cnt[0] == $past(err_cnt[0]) ||
                        err_cnt[0] == $past(err_cnt[0]) + 16'h0001;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("error count moved by more than one");

  property p_no_strobe;
    @(posedge mclk) disable iff (!reset_n)
      !tim.bit_strobe && !clear_vec[0] |=> $stable(err_cnt[0]);
  endproperty
  a_no_strobe: assert property (p_no_strobe)
    else $error("error counted without a bit");

  property p_read_err;
    @(posedge mclk) disable iff (!reset_n)
      reg_rd && reg_addr == 8'h03 |=> reg_rdata == $past(err_cnt[0]);
  endproperty
  a_read_err: assert property (p_read_err)
    else $error("error count readback wrong");

  property p_start_rb;
    @(posedge mclk) disable iff (!reset_n)
      reg_wr && reg_addr == 8'h01 ##1 reg_rd && reg_addr == 8'h01 && !reg_wr
      |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)};
  endproperty
  a_start_rb: assert property (p_start_rb)
    else $error("start channel readback wrong");

  c_tx_active: cover property (@(posedge mclk) tx_on[0] && tim.bit_strobe);
  c_err_count: cover property (@(posedge mclk) err_cnt[0] != 16'h0000);
  c_rx_enable: cover property (@(posedge mclk) rx_glob_q && cfg_q[0].enable);

endmodule

// file: verif/pbt_far_end.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// far-end equipment sending the test pattern into the input streams
// ----------------------------------------------------------------
module pbt_far_end (
  input  wire logic mclk,     // 10 MHz clock
  input  wire logic reset_n,  // async reset
  input  wire logic restart,  // frame start, reseeds pattern
  input  wire logic strobe,   // one bit time
  input  wire logic send,     // bit lies in the test window
  input  wire logic flip,     // corrupt this bit
  output logic      rx_bit    // line toward the switch
);
  logic [14:0] s_q, s_d;
  logic        last_q, last_d;
  // pattern steps only on bits that are sent
  always_comb begin
    s_d    = restart ? 15'h7FFF : s_q;
    last_d = last_q;
    if (strobe && send) begin
      s_d    = {s_q[13:0], s_q[14] ^ s_q[13]};
      last_d = rx_bit;
    end
  end
  // contiguous window, same length as the checker's; idle shows inverse
  assign rx_bit = send ? s_q[14] ^ flip : ~last_q;
  // pattern registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q    <= 15'h7FFF;
      last_q <= 1'b0;
    end else begin
      s_q    <= s_d;
      last_q <= last_d;
    end
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ----------------------------------------------------------------
// bench for the per-stream error rate test block
// ----------------------------------------------------------------
module tb;
  logic                 mclk, reset_n, reg_wr, reg_rd, send, flip, far_bit;
  logic [7:0]           reg_addr;
  logic [15:0]          reg_wdata, reg_rdata;
  pbt_pkg::pbt_timing_t tim;
  logic [31:0]          rx_bits, tx_bits, tx_on;
  logic [31:0][2:0]     cm_low;
  logic [14:0]          ts;
  int                   bad_count, n_checks;

  // clock and fan-out of the far-end line
  always #50 mclk = ~mclk;
  assign rx_bits = {32{far_bit}};

  pbt_top pbt_top_i (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tim(tim), .rx_bits(rx_bits),
    .cm_low(cm_low), .tx_bits(tx_bits), .tx_on(tx_on));
  pbt_far_end pbt_far_end_i (.mclk(mclk), .reset_n(reset_n),
    .restart(tim.frame_start), .strobe(tim.bit_strobe), .send(send),
    .flip(flip), .rx_bit(far_bit));

  // ----------------------------------------------------------------
  // bus and frame tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] ad(input int s, input logic [1:0] r);
    return {1'b0, 5'(s), r};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // write, then read the same register on the very next cycle
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d,
                      input logic [15:0] e);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // one frame; window [lo,hi) carries pattern, first nerr bits corrupted
  task automatic frame(input int nch, lo, hi, nerr, input logic [2:0] cm,
                       input logic txg);
    int   i;
    logic in_w, on, eo, eb, pon;
    i = 0;
    eo = 0;
    eb = 0;
    pon = 0;
    @(posedge mclk);
    tim <= '{frame_start:1'b1, default:'0};
    for (int k = 0; k < nch * 8 + 1; k++) begin
      @(posedge mclk);
      in_w = (k / 8 >= lo) && (k / 8 < hi) && k < nch * 8;
      tim  <= '{frame_start:1'b0, bit_strobe:(k < nch * 8),
               first_bit:(k % 8 == 0), chan:8'(k / 8)};
      send <= in_w;
      flip <= in_w && (i < nerr);
      cm_low <= {32{in_w ? cm : 3'b000}};
      if (in_w)
        i++;
      #1;
      `CHK(tx_on, {32{eo}})
      `CHK(tx_bits, {32{eb}})
      on = txg && in_w && cm == 3'b101;
      if (on && !pon)
        ts = 15'h7FFF;
      eo = on;
      eb = on & ts[14];
      if (on)
        ts = {ts[13:0], ts[14] ^ ts[13]};
      pon = on;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(8'h80, 16'h0000);
    rdc(ad(0, pbt_pkg::REG_CONTROL), 16'h0000);
    rdc(ad(0, pbt_pkg::REG_START), 16'h0000);
    rdc(ad(31, pbt_pkg::REG_LENGTH), 16'h0001);
    rdc(ad(7, pbt_pkg::REG_ERRORS), 16'h0000);
  endtask
  task automatic t_regs;
    wrrd(ad(0, pbt_pkg::REG_START), 16'hAB5A, 16'h005A);
    wr(ad(5, pbt_pkg::REG_START), 16'hFFFF);
    rdc(ad(5, pbt_pkg::REG_START), 16'h00FF);
    wr(ad(5, pbt_pkg::REG_LENGTH), 16'h0100);
    rdc(ad(5, pbt_pkg::REG_LENGTH), 16'h0100);
    wr(ad(5, pbt_pkg::REG_LENGTH), 16'h0000);
    rdc(ad(5, pbt_pkg::REG_LENGTH), 16'h0001);
    wr(ad(5, pbt_pkg::REG_ERRORS), 16'h1234);
    rdc(ad(5, pbt_pkg::REG_ERRORS), 16'h0000);
    wr(8'h81, 16'hFFFF);
    rdc(8'h81, 16'h0000);
    rdc(8'h80, 16'h0000);
  endtask
  task automatic t_tx;
    logic [2:0] cms[6] = '{3'b101, 3'b100, 3'b111, 3'b001, 3'b011, 3'b110};
    wr(8'h80, 16'h0010);
    rdc(8'h80, 16'h0010);
    foreach (cms[j])
      frame(4, 1, 3, 0, cms[j], 1'b1);
    frame(8, 0, 8, 0, 3'b101, 1'b1);
    wr(8'h80, 16'h0000);
    frame(4, 1, 3, 0, 3'b101, 1'b0);
  endtask
  task automatic t_rx;
    wr(8'h80, 16'h0020);
    rdc(8'h80, 16'h0020);
    for (int s = 0; s < 32; s += 31) begin
      wr(ad(s, pbt_pkg::REG_START), 16'h0002);
      wr(ad(s, pbt_pkg::REG_LENGTH), 16'h0003);
      wr(ad(s, pbt_pkg::REG_CONTROL), 16'h0003);
    end
    rdc(ad(31, pbt_pkg::REG_CONTROL), 16'h0001);
    repeat (2) frame(6, 2, 5, 0, 3'b000, 1'b0);
    rdc(ad(0, pbt_pkg::REG_ERRORS), 16'h0000);
    frame(6, 2, 5, 5, 3'b000, 1'b0);
    rdc(ad(0, pbt_pkg::REG_ERRORS), 16'h0005);
    rdc(ad(31, pbt_pkg::REG_ERRORS), 16'h0005);
    rdc(ad(1, pbt_pkg::REG_ERRORS), 16'h0000);
    wr(8'h80, 16'h0000);
    frame(6, 2, 5, 5, 3'b000, 1'b0);
    rdc(ad(0, pbt_pkg::REG_ERRORS), 16'h0005);
    wr(8'h80, 16'h0020);
    wr(ad(0, pbt_pkg::REG_CONTROL), 16'h0002);
    rdc(ad(0, pbt_pkg::REG_CONTROL), 16'h0000);
    rdc(ad(0, pbt_pkg::REG_ERRORS), 16'h0000);
    frame(6, 2, 5, 5, 3'b000, 1'b0);
    rdc(ad(0, pbt_pkg::REG_ERRORS), 16'h0000);
    rdc(ad(31, pbt_pkg::REG_ERRORS), 16'h000A);
  endtask
  task automatic t_sat;
    wr(ad(0, pbt_pkg::REG_START), 16'h0000);
    wr(ad(0, pbt_pkg::REG_LENGTH), 16'h0100);
    wr(ad(0, pbt_pkg::REG_CONTROL), 16'h0001);
    repeat (33) frame(256, 0, 256, 4096, 3'b000, 1'b0);
    rdc(ad(0, pbt_pkg::REG_ERRORS), 16'hFFFF);
  endtask

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #9000000;
    bad_count++;
    end_of_test;
  end
  // reset, then every scenario in turn
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    tim = '0;
    cm_low = '0;
    send = 1'b0;
    flip = 1'b0;
    ts = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_regs;
    t_tx;
    t_rx;
    t_sat;
    end_of_test;
  end
endmodule
